// ==== fsc_status_ctrl.sv ====
// Status/control word and command framing of a serial flash.
// Assumes the host stops sclk while cs_n is high and holds cs_n high
// for at least three mclk periods between frames.
// Functional notes
// - Busy bit high during program, erase, status write
// - Latch clear refuses writes, programs, erases
// - Status write loads block protect bits
// - Block protect frozen under hardware protection
// - Chip erase with unprotected code, or with complement and bp_q xx101 or xx11x
// - Mode 00 allows writes with latch set
// - Mode 01 blocks writes while pin low
// - Mode 10 locks until power cycle
// - Mode 11 locks status until power cycle, as mode 10
// - Quad bit turns protect pins into data
// - Security lock bit set by status write, cleared by power cycle
// - Complement bit inverts protected region
// - Suspend sets, resume clears pause flag
// - Bits sampled MSB first on rising edges
// - Frame opens with one command byte
// - Status reads shift out until deselect
// - Writes need byte-aligned clock count
// - Partial page byte keeps latch, no program
// - Latch set by enable, cleared by writes
`include "fsc_consts.svh"
`default_nettype none
module fsc_status_ctrl #(
    parameter int PP_CYC = `FSC_T_PP_US * `FSC_MCLK_MHZ,
    parameter int SE_CYC = `FSC_T_SE_US * `FSC_MCLK_MHZ,
    parameter int BE32_CYC = `FSC_T_BE32_US * `FSC_MCLK_MHZ,
    parameter int BE64_CYC = `FSC_T_BE64_US * `FSC_MCLK_MHZ,
    parameter int CE_CYC = `FSC_T_CE_US * `FSC_MCLK_MHZ,
    parameter int SRW_CYC = `FSC_T_SRW_US * `FSC_MCLK_MHZ
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    input wire logic wp_n,
    output logic quad_pins_en,
    output logic [15:0] status_word
);
    // ====================================================
    // Link side, on sclk
    logic frm_rst;
    logic first_q;
    logic tog_q;
    logic rd_q;
    logic hi_q;
    logic [2:0] nb_q;
    logic [2:0] byte_q;
    logic [7:0] sh_q;
    logic [7:0] buf_q [0:5];
    logic [15:0] ss1_q;
    logic [15:0] ss2_q;
    logic [6:0] osh_q;
    logic so_q;
    logic [7:0] in_byte;

    assign frm_rst = cs_n | ~rst_n;
    assign in_byte = {sh_q[6:0], si};

    always_ff @(posedge sclk or posedge frm_rst) begin
        if (frm_rst) begin
            first_q <= 1'h1;
        end else begin
            first_q <= 1'h0;
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            nb_q <= 3'h0;
            byte_q <= 3'h0;
            sh_q <= 8'h00;
            tog_q <= 1'h0;
        end else begin
            sh_q <= in_byte;
            nb_q <= first_q ? 3'h1 : 3'(nb_q + 3'h1);
            if (first_q) begin
                tog_q <= ~tog_q;
                byte_q <= 3'h0;
            end else if (nb_q == `FSC_BIT_LAST && byte_q != `FSC_NB_MAX) begin
                byte_q <= 3'(byte_q + 3'h1);
            end
        end
    end

    always_ff @(posedge sclk) begin
        if (!first_q && nb_q == `FSC_BIT_LAST && byte_q != `FSC_NB_MAX) begin
            buf_q[byte_q] <= in_byte;
        end
    end

    always_ff @(posedge sclk or posedge frm_rst) begin
        if (frm_rst) begin
            rd_q <= 1'h0;
            hi_q <= 1'h0;
        end else if (first_q) begin
            rd_q <= 1'h0;
        end else if (nb_q == `FSC_BIT_LAST && byte_q == 3'h0) begin
            rd_q <= in_byte == `FSC_OP_RDSR_LO || in_byte == `FSC_OP_RDSR_HI;
            hi_q <= in_byte == `FSC_OP_RDSR_HI;
        end
    end

    // Status level crossing; refreshed on every sclk rising edge
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            ss1_q <= 16'h0000;
            ss2_q <= 16'h0000;
        end else begin
            ss1_q <= status_word;
            ss2_q <= ss1_q;
        end
    end

    // byte snapshot, shifted on falling edges
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            so_q <= 1'h0;
            osh_q <= 7'h00;
        end else if (nb_q == 3'h0) begin
            {so_q, osh_q} <= hi_q ? ss2_q[15:8] : ss2_q[7:0];
        end else begin
            so_q <= osh_q[6];
            osh_q <= {osh_q[5:0], 1'h0};
        end
    end

    assign so = so_q;
    assign so_oe = ~cs_n & rd_q;

    // ====================================================
    // Crossings into mclk
    logic cs1_q, cs2_q, cs3_q, wp1_q, wp2_q, tg1_q, tg2_q, seen_q;
    logic ev;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {cs1_q, cs2_q, cs3_q} <= 3'h7;
            {wp1_q, wp2_q} <= 2'h3;
            {tg1_q, tg2_q, seen_q} <= 3'h0;
        end else begin
            {cs1_q, cs2_q, cs3_q} <= {cs_n, cs1_q, cs2_q};
            {wp1_q, wp2_q} <= {wp_n, wp1_q};
            {tg1_q, tg2_q} <= {tog_q, tg1_q};
            if (cs2_q && !cs3_q) begin
                seen_q <= tg2_q;
            end
        end
    end

    // Clocked frames only; a select pulse alone does nothing
    assign ev = cs2_q & ~cs3_q & (tg2_q != seen_q);

    // ====================================================
    // Command decode at frame end
    logic wel_q, sus_q, run_q, qe_q, lb_q, cmp_q;
    logic [1:0] srp_q;
    logic [4:0] bp_q;
    logic [`FSC_TMR_W-1:0] tmr_q;
    fsc_pkg::fsc_op_t op_q;
    fsc_pkg::fsc_op_t op_d;
    logic [`FSC_TMR_W-1:0] len_d;
    logic [7:0] cmd;
    logic [19:0] addr;
    logic aligned, busy, gate, hw_lock, srw_ok, ce_ok, prot;
    logic go_srw, go_op, latch_set_cmd, latch_clear_cmd, go_sus, go_res;

    // region chosen by protect bits and complement
    function automatic logic fsc_prot(input logic [19:0] a,
                                      input logic [4:0] bp,
                                      input logic cmp);
        logic [20:0] sz;
        logic [1:0] k;
        logic hit;
        k = bp[2] ? 2'h3 : 2'(bp[1:0] - 2'h1);
        sz = (bp[4] ? `FSC_SEC_SZ : `FSC_BLK_SZ) << k;
        if (bp[2:0] == 3'h0) begin
            hit = 1'h0;
        end else if (bp[2:1] == 2'h3 || (bp[2:0] == 3'h5 && !bp[4])) begin
            hit = 1'h1;
        end else if (bp[3]) begin
            hit = {1'h0, a} < sz;
        end else begin
            hit = {1'h0, a} >= 21'(`FSC_MEM_TOP - sz);
        end
        return hit ^ cmp;
    endfunction : fsc_prot

    assign cmd = buf_q[0];
    assign addr = {buf_q[1][3:0], buf_q[2], buf_q[3]};
    assign aligned = nb_q == 3'h0;
    assign busy = run_q & ~sus_q;
    assign gate = ev & aligned & ~run_q & wel_q;
    // pin is data, not protect, under quad
    assign hw_lock = srp_q == 2'h1 & ~wp2_q & ~qe_q;
    assign srw_ok = srp_q == 2'h0 | (srp_q == 2'h1 & ~hw_lock);
    // chip erase when nothing is protected, or with complement and bp_q xx101 or xx11x
    assign ce_ok = cmp_q ? (bp_q[2:0] == 3'h5 || bp_q[2:1] == 2'h3)
                         : bp_q[2:0] == 3'h0;
    assign prot = fsc_prot(addr, bp_q, cmp_q);
    assign go_srw = gate & cmd == `FSC_OP_STATUS_WRITE_CMD & byte_q >= `FSC_NB_SRW
                  & srw_ok;
    assign latch_set_cmd = ev & aligned & ~busy & cmd == `FSC_OP_LATCH_SET_CMD
                & byte_q == `FSC_NB_CMD;
    assign latch_clear_cmd = ev & aligned & ~busy & cmd == `FSC_OP_LATCH_CLEAR_CMD
                & byte_q == `FSC_NB_CMD;
    // pause only a program or erase
    assign go_sus = ev & aligned & busy & cmd == `FSC_OP_SUSP
                  & op_q != fsc_pkg::FSC_OP_SRW;
    assign go_res = ev & aligned & sus_q & cmd == `FSC_OP_RESM;

    // partial bytes and protected targets start nothing
    always_comb begin
        op_d = fsc_pkg::FSC_OP_NONE;
        len_d = `FSC_TMR_W'(SRW_CYC);
        if (go_srw) begin
            op_d = fsc_pkg::FSC_OP_SRW;
        end else if (gate && cmd == `FSC_OP_PP && byte_q >= `FSC_NB_PP
                     && !prot) begin
            op_d = fsc_pkg::FSC_OP_PROG;
            len_d = `FSC_TMR_W'(PP_CYC);
        end else if (gate && byte_q == `FSC_NB_ADR && !prot
                     && cmd == `FSC_OP_SE) begin
            op_d = fsc_pkg::FSC_OP_SERA;
            len_d = `FSC_TMR_W'(SE_CYC);
        end else if (gate && byte_q == `FSC_NB_ADR && !prot
                     && cmd == `FSC_OP_BE32) begin
            op_d = fsc_pkg::FSC_OP_BE32;
            len_d = `FSC_TMR_W'(BE32_CYC);
        end else if (gate && byte_q == `FSC_NB_ADR && !prot
                     && cmd == `FSC_OP_BE64) begin
            op_d = fsc_pkg::FSC_OP_BE64;
            len_d = `FSC_TMR_W'(BE64_CYC);
        end else if (gate && byte_q == `FSC_NB_CMD && ce_ok
                     && (cmd == `FSC_OP_CE_A || cmd == `FSC_OP_CE_B)) begin
            op_d = fsc_pkg::FSC_OP_CHIP;
            len_d = `FSC_TMR_W'(CE_CYC);
        end
    end
    assign go_op = op_d != fsc_pkg::FSC_OP_NONE;

    // ====================================================
    // State registers
    // latch set and clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wel_q <= 1'h0;
        end else if (latch_set_cmd) begin
            wel_q <= 1'h1;
        end else if (latch_clear_cmd || go_op) begin
            wel_q <= 1'h0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'h0;
            tmr_q <= '0;
            op_q <= fsc_pkg::FSC_OP_NONE;
        end else if (go_op) begin
            run_q <= 1'h1;
            tmr_q <= len_d;
            op_q <= op_d;
        end else if (busy) begin
            run_q <= tmr_q != `FSC_TMR_END;
            tmr_q <= `FSC_TMR_W'(tmr_q - `FSC_TMR_END);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sus_q <= 1'h0;
        end else if (go_sus) begin
            sus_q <= 1'h1;
        end else if (go_res) begin
            sus_q <= 1'h0;
        end
    end

    // status write; reset stands for a power cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {bp_q, srp_q, qe_q, lb_q, cmp_q} <= 10'h000;
        end else if (go_srw) begin
            bp_q <= buf_q[1][6:2];
            srp_q[0] <= buf_q[1][7];
            if (byte_q >= `FSC_NB_SRW2) begin
                srp_q[1] <= buf_q[2][0];
                qe_q <= buf_q[2][1];
                lb_q <= lb_q | buf_q[2][2];
                cmp_q <= buf_q[2][6];
            end
        end
    end

    assign status_word = {sus_q, cmp_q, 3'h0, lb_q, qe_q, srp_q[1],
                          srp_q[0], bp_q, wel_q, busy};
    assign quad_pins_en = qe_q;

    // ====================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_wip_on_start: assert property (go_op |=> status_word[0])
        else $error("busy bit not set after start");
    a_wel_refuse: assert property (!wel_q |=> !$rose(run_q))
        else $error("operation started without latch");
    a_bp_hwlock: assert property (hw_lock && ev |=> $stable(bp_q))
        else $error("protect bits changed under lock");
    a_ce_gate: assert property ($rose(run_q) && op_q == fsc_pkg::FSC_OP_CHIP
        |-> $past(ce_ok))
        else $error("chip erase with protected code");
    a_srp_lock: assert property (srp_q[1] |=> $stable(bp_q) && $stable(cmp_q)
        && $stable(srp_q) && $stable(qe_q))
        else $error("status changed while locked");
    a_lb_otp: assert property (lb_q |=> lb_q)
        else $error("security lock cleared");
    a_sus_set: assert property (go_sus |=> sus_q && !status_word[0])
        else $error("suspend not taken");
    a_frame_align: assert property (ev && !aligned
        |=> $stable(wel_q) && !$rose(run_q))
        else $error("misaligned frame acted on");
    a_wel_clear: assert property ($rose(run_q) |-> !wel_q)
        else $error("latch not cleared by operation");
    a_srw_mode0: assert property (ev && aligned && wel_q && !run_q
        && srp_q == 2'h0 && cmd == `FSC_OP_STATUS_WRITE_CMD && byte_q >= `FSC_NB_SRW
        |=> run_q ##1 !wel_q)
        else $error("status write refused in mode 00");

    c_prog: cover property (go_op && op_d == fsc_pkg::FSC_OP_PROG);
    c_srw: cover property (go_srw);
    c_susp: cover property (go_sus ##[1:200] go_res);
    c_read: cover property (cs2_q && !cs3_q && rd_q);
endmodule : fsc_status_ctrl
`default_nettype wire

// ==== fsc_consts.svh ====
// Opcodes, frame lengths and operation times of the status block.
// Assumes a 10 MHz mclk; times are in microseconds.
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH
// ====================================================
// Opcodes
`define FSC_OP_LATCH_SET_CMD 8'h06
`define FSC_OP_LATCH_CLEAR_CMD 8'h04
`define FSC_OP_RDSR_LO 8'h05
`define FSC_OP_RDSR_HI 8'h35
`define FSC_OP_STATUS_WRITE_CMD 8'h01
`define FSC_OP_PP 8'h02
`define FSC_OP_SE 8'h20
`define FSC_OP_BE32 8'h52
`define FSC_OP_BE64 8'hD8
`define FSC_OP_CE_A 8'hC7
`define FSC_OP_CE_B 8'h60
`define FSC_OP_SUSP 8'h75
`define FSC_OP_RESM 8'h7A
// ====================================================
// Frame lengths in whole bytes, and the last bit index within a byte
`define FSC_NB_CMD 3'h1
`define FSC_NB_SRW 3'h2
`define FSC_NB_SRW2 3'h3
`define FSC_NB_ADR 3'h4
`define FSC_NB_PP 3'h5
`define FSC_NB_MAX 3'h6
`define FSC_BIT_LAST 3'h7
// ====================================================
// Array geometry and timing
`define FSC_MEM_TOP 21'h100000
`define FSC_BLK_SZ 21'h010000
`define FSC_SEC_SZ 21'h001000
`define FSC_TMR_W 27
`define FSC_TMR_END 27'h0000001
`define FSC_MCLK_MHZ 10
`define FSC_T_PP_US 700
`define FSC_T_SE_US 100000
`define FSC_T_BE32_US 200000
`define FSC_T_BE64_US 400000
`define FSC_T_CE_US 8000000
`define FSC_T_SRW_US 5000
`endif

// ==== fsc_pkg.sv ====
// Types shared by the status block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package fsc_pkg;
    typedef enum logic [2:0] {
        FSC_OP_NONE, FSC_OP_PROG, FSC_OP_SERA, FSC_OP_BE32,
        FSC_OP_BE64, FSC_OP_CHIP, FSC_OP_SRW
    } fsc_op_t;
endpackage : fsc_pkg
`default_nettype wire

// ==== fsc_host_model.sv ====
// SPI host model for the link side of the status block.
// Assumes the device samples si on sclk rise and shifts so on fall.
`default_nettype none
module fsc_host_model (
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF = 16;
    // Device drive level seen as each frame opens
    logic oe_at_open;
    initial begin
        oe_at_open = 1'b0;
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // ================================================
    // Bit shifting
    // MSB first, command byte leads
    task automatic shift(input logic [39:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            si = d[39 - i];
            #HALF sclk = 1'b1;
            #HALF sclk = 1'b0;
        end
    endtask : shift
    // ================================================
    // Frames
    // select raised after last bit
    task automatic frame(input logic [39:0] d, input int n);
        cs_n = 1'b0;
        #HALF;
        oe_at_open = so_oe;
        shift(d, n);
        #HALF cs_n = 1'b1;
        // Released line must not keep the last bit
        si = ~si;
        #400;
    endtask : frame
    // read phase of 16 bits after the command byte
    task automatic read(input logic [7:0] cmd, output logic [15:0] q,
                        output logic oe);
        cs_n = 1'b0;
        #HALF;
        shift({cmd, 32'h00000000}, 8);
        oe = so_oe;
        for (int i = 0; i < 16; i++) begin
            si = ~si;
            #HALF q = {q[14:0], so};
            sclk = 1'b1;
            #HALF sclk = 1'b0;
        end
        #HALF cs_n = 1'b1;
        #400;
    endtask : read
endmodule : fsc_host_model
`default_nettype wire

// ==== tb_flash_status_and_command_framing.sv ====
// Self-checking bench of the status block, reset first, then rows, then by hand.
// Assumes fsc_status_ctrl and fsc_host_model are compiled before it.
`default_nettype none
module tb_flash_status_and_command_framing;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic rs;
        logic wp;
        logic [5:0] n;
        logic [23:0] d;
        logic [15:0] e;
    } fsc_row_t;
    // ================================================
    // Ordinary cases: reset, wp_n, bits, frame, status after
    localparam fsc_row_t ROWS [23] = '{
        '{1'b0, 1'b1, 6'h08, 24'h060000, 16'h0002},
        '{1'b0, 1'b1, 6'h08, 24'h040000, 16'h0000},
        '{1'b0, 1'b1, 6'h18, 24'h011C00, 16'h0000},
        '{1'b0, 1'b1, 6'h08, 24'h060000, 16'h0002},
        '{1'b0, 1'b1, 6'h0F, 24'h010C00, 16'h0002},
        '{1'b0, 1'b1, 6'h18, 24'h010C78, 16'h400C},
        '{1'b0, 1'b1, 6'h08, 24'h060000, 16'h400E},
        '{1'b0, 1'b1, 6'h20, 24'h200500, 16'h400E},
        '{1'b0, 1'b1, 6'h20, 24'h200C00, 16'h400C},
        '{1'b0, 1'b1, 6'h08, 24'h060000, 16'h400E},
        '{1'b0, 1'b1, 6'h08, 24'hC70000, 16'h400E},
        '{1'b0, 1'b0, 6'h10, 24'h019400, 16'h4094},
        '{1'b0, 1'b0, 6'h08, 24'h060000, 16'h4096},
        '{1'b0, 1'b0, 6'h08, 24'hC70000, 16'h4094},
        '{1'b0, 1'b0, 6'h08, 24'h060000, 16'h4096},
        '{1'b0, 1'b0, 6'h18, 24'h010000, 16'h4096},
        '{1'b0, 1'b1, 6'h18, 24'h010005, 16'h0500},
        '{1'b0, 1'b1, 6'h08, 24'h060000, 16'h0502},
        '{1'b0, 1'b1, 6'h18, 24'h010000, 16'h0502},
        '{1'b1, 1'b1, 6'h08, 24'h060000, 16'h0002},
        '{1'b0, 1'b1, 6'h18, 24'h018003, 16'h0380},
        '{1'b0, 1'b1, 6'h08, 24'h060000, 16'h0382},
        '{1'b0, 1'b1, 6'h18, 24'h010000, 16'h0382}
    };
    logic mclk;
    logic rst_n;
    logic wp_n;
    logic sclk;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe;
    logic quad_pins_en;
    logic [15:0] status_word;
    logic [15:0] q;
    logic oe;
    int n_errors;
    int cmp_count;
    // Short operation times keep the run brief
    localparam int T_OP = 40;
    // 64K block erase keeps its full time; never started here
    fsc_status_ctrl #(.PP_CYC(T_OP), .SE_CYC(T_OP), .BE32_CYC(T_OP),
        .CE_CYC(T_OP), .SRW_CYC(T_OP)) dut (
        .mclk(mclk),
        .rst_n(rst_n),
        .sclk(sclk),
        .cs_n(cs_n),
        .si(si),
        .so(so),
        .so_oe(so_oe),
        .wp_n(wp_n),
        .quad_pins_en(quad_pins_en),
        .status_word(status_word)
    );
    fsc_host_model host (
        .sclk(sclk),
        .cs_n(cs_n),
        .si(si),
        .so(so),
        .so_oe(so_oe)
    );
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;
    // ================================================
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic ticks(input int k);
        repeat (k) @(posedge mclk);
        #5;
    endtask : ticks
    // ================================================
    // Watchdog, about five times the expected run
    initial begin
        #1000000;
        n_errors++;
        give_verdict;
    end
    // ================================================
    // Main sequence
    initial begin
        n_errors = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        wp_n = 1'b1;
        ticks(8);
        chk(status_word, 16'h0000, "reset word");
        chk({14'h0000, so_oe, quad_pins_en}, 16'h0000, "reset pins");
        rst_n = 1'b1;
        ticks(2);
        $display("reset test done");
        // Pins are driven, never tied, so quad may be set in row 20
        foreach (ROWS[i]) begin
            if (ROWS[i].rs) begin
                rst_n = 1'b0;
                ticks(3);
                chk(status_word, 16'h0000, "power cycle");
                rst_n = 1'b1;
            end
            wp_n = ROWS[i].wp;
            ticks(4);
            host.frame({ROWS[i].d, 16'h0000}, ROWS[i].n);
            ticks(60);
            chk(status_word, ROWS[i].e, "row word");
            chk({15'h0000, quad_pins_en}, {15'h0000, ROWS[i].e[9]},
                "quad");
            $display("row %0d done", i);
        end
        // Status byte repeats until deselect
        host.read(8'h05, q, oe);
        chk(q, 16'h8282, "status read");
        chk({15'h0000, oe}, 16'h0001, "drive on");
        chk({15'h0000, so_oe}, 16'h0000, "drive off");
        host.frame(40'h0400000000, 8);
        chk({15'h0000, host.oe_at_open}, 16'h0000, "drive at open");
        $display("read test done");
        rst_n = 1'b0;
        ticks(3);
        rst_n = 1'b1;
        ticks(2);
        host.frame(40'h0600000000, 8);
        host.frame(40'h02000000AB, 39);
        ticks(60);
        chk(status_word, 16'h0002, "partial page");
        host.frame(40'h02000000AB, 40);
        ticks(6);
        chk(status_word, 16'h0001, "program start");
        host.frame(40'h7500000000, 8);
        ticks(6);
        chk(status_word, 16'h8000, "suspend");
        host.frame(40'h7A00000000, 8);
        ticks(6);
        chk(status_word, 16'h0001, "resume");
        for (int k = 0; k < 100 && status_word[0] !== 1'b0; k++) begin
            ticks(1);
        end
        chk(status_word, 16'h0000, "program end");
        $display("program test done");
        give_verdict;
    end
endmodule : tb_flash_status_and_command_framing
`default_nettype wire
